// >>> flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model
  import flash_self_prog_pkg::*;
(
  // Address from the block.
  input wire logic [PTR_WIDTH-1:0] flashAddr,
  // Byte returned to the block.
  output logic [7:0] flashRdData
);
  // Each byte reads as a fold of address bits 14 to 0 and the space bit, so a wrong address in those bits shows.
  assign flashRdData = flashAddr[7:0] ^ {flashAddr[21], flashAddr[14:8]};
endmodule : flash_array_model

// >>> flash_self_prog_pkg.sv
package flash_self_prog_pkg;
  // Register selects on the special-function register port.
  localparam logic [2:0] SEL_CONTROL = 3'h0;
  localparam logic [2:0] SEL_UNLOCK = 3'h1;
  localparam logic [2:0] SEL_LATCH = 3'h2;
  localparam logic [2:0] SEL_PTR_LOW = 3'h3;
  localparam logic [2:0] SEL_PTR_HIGH = 3'h4;
  localparam logic [2:0] SEL_PTR_UPPER = 3'h5;
  // Field positions in memory_access_control.
  localparam int BIT_MEM_SEL = 7;
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_FREE = 4;
  localparam int BIT_WR_ERR = 3;
  localparam int BIT_WR_EN = 2;
  localparam int BIT_WR = 1;
  localparam int BIT_RD = 0;
  // Unlock sequence values.
  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
  // Geometry.
  localparam int PTR_WIDTH = 22;
  localparam int BLOCK_BYTES = 8;
  localparam int ROW_BYTES = 64;
  localparam int BLOCK_LSBS = 3;
  localparam int ROW_LSBS = 6;
  // Reset values.
  localparam logic [21:0] PTR_RESET = 22'h000000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // Programming time and its cycle count at the core clock.
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int PROG_TIME_US = 2000;
  localparam int PROG_CYCLES = (PROG_TIME_US * 1000) / CLOCK_PERIOD_NS;
  localparam int TIMER_WIDTH = 15;
  typedef enum logic [1:0] {PTR_KEEP, PTR_POST_INC, PTR_POST_DEC, PTR_PRE_INC} ptr_action_t;
  typedef enum logic [1:0] {SPACE_EEPROM, SPACE_PROGRAM, SPACE_CONFIG} space_t;
  typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_HALF, UNLOCK_OPEN} unlock_t;
endpackage : flash_self_prog_pkg

// >>> holding_register_bank.sv
`timescale 1ns/1ps
module holding_register_bank
  import flash_self_prog_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Byte load port.
  input wire logic loadEn,
  input wire logic lock,
  input wire logic [2:0] index,
  input wire logic [7:0] loadData,
  // Block contents, byte 0 in the low bits.
  output logic [8*BLOCK_BYTES-1:0] blockData
);
  genvar g;
  // Each entry takes the latch when its index is selected and not locked.
  generate
    for (g = 0; g < BLOCK_BYTES; g++) begin : g_entry
      logic [7:0] next_entry;
      always_comb begin
        next_entry = blockData[8*g +: 8];
        if (loadEn && !lock && index == 3'(g)) begin
          next_entry = loadData;
        end
      end
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          blockData[8*g +: 8] <= BYTE_RESET;
        end else begin
          blockData[8*g +: 8] <= next_entry;
        end
      end
    end
  endgenerate
endmodule : holding_register_bank

// >>> program_flash_self_programming.sv
`timescale 1ns/1ps
module program_flash_self_programming
  import flash_self_prog_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
  // Clock and resets.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic porRst_n,
  // Special-function register port.
  input wire logic [2:0] sfrSel,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Table instructions.
  input wire logic tableReadReq,
  input wire logic tableWriteReq,
  input wire ptr_action_t tableMode,
  // Memory array side.
  output logic [PTR_WIDTH-1:0] flashAddr,
  input wire logic [7:0] flashRdData,
  output logic [8*BLOCK_BYTES-1:0] holdingData,
  output logic longWriteStart,
  output logic eraseRow,
  output space_t targetSpace,
  output logic eepromReadStart,
  // Core status.
  output logic fetchStall,
  output logic writeCompleteFlag,
  input wire logic writeCompleteClear
);
  // State kept across warm resets, except busy, which a warm reset clears, and writeError, which a warm reset sets if busy was high.
  logic busy, memSel, cfgSel, writeError;
  // Ordinary control state.
  logic [PTR_WIDTH-1:0] ptr;
  logic [7:0] latch;
  logic free, writeEnable, rdBit, readPending;
  unlock_t unlock;
  logic timerDone;
  // Decoded strobes.
  logic ctrlWr, unlockWr, startReq, readStart, tableOk;
  logic [PTR_WIDTH-1:0] effPtr;
  logic [PTR_WIDTH-1:0] next_ptr;
  logic [7:0] next_latch;
  logic next_free, next_writeEnable, next_rdBit, next_readPending;
  unlock_t next_unlock;
  logic next_busy, next_memSel, next_cfgSel, next_writeError;
  logic [PTR_WIDTH-1:0] next_flashAddr;
  logic next_longWriteStart, next_eraseRow;
  space_t next_targetSpace;
  logic next_eepromReadStart, next_fetchStall, next_writeCompleteFlag;
  logic [7:0] next_sfrRdData;

  // Register port decode and the start conditions.
  always_comb begin
    ctrlWr = sfrWrite && sfrSel == SEL_CONTROL;
    unlockWr = sfrWrite && sfrSel == SEL_UNLOCK;
    startReq = ctrlWr && sfrWrData[BIT_WR] && writeEnable && unlock == UNLOCK_OPEN && !busy;
    readStart = ctrlWr && sfrWrData[BIT_RD] && !memSel && !rdBit && !busy;
    tableOk = !busy;
  end

  // Effective table address for the access itself.
  always_comb begin
    effPtr = ptr;
    if (tableMode == PTR_PRE_INC) begin
      effPtr = {ptr[PTR_WIDTH-1], ptr[PTR_WIDTH-2:0] + 21'h000001};
    end
  end

  // Pointer and latch next values.
  always_comb begin
    next_ptr = ptr;
    next_latch = latch;
    next_readPending = tableReadReq && tableOk;
    if ((tableReadReq || tableWriteReq) && tableOk) begin
      case (tableMode)
        PTR_POST_INC: next_ptr = {ptr[PTR_WIDTH-1], ptr[PTR_WIDTH-2:0] + 21'h000001};
        PTR_POST_DEC: next_ptr = {ptr[PTR_WIDTH-1], ptr[PTR_WIDTH-2:0] - 21'h000001};
        PTR_PRE_INC: next_ptr = effPtr;
        default: next_ptr = ptr;
      endcase
    end
    if (sfrWrite) begin
      if (sfrSel == SEL_PTR_LOW) begin
        next_ptr[7:0] = sfrWrData;
      end else if (sfrSel == SEL_PTR_HIGH) begin
        next_ptr[15:8] = sfrWrData;
      end else if (sfrSel == SEL_PTR_UPPER) begin
        next_ptr[21:16] = sfrWrData[5:0];
      end else if (sfrSel == SEL_LATCH) begin
        next_latch = sfrWrData;
      end
    end
    if (readPending) begin
      next_latch = flashRdData;
    end
  end

  // Control bits that reset with the warm reset.
  always_comb begin
    next_free = free;
    next_writeEnable = writeEnable;
    next_rdBit = 1'b0;
    next_unlock = unlock;
    if (ctrlWr && !busy) begin
      next_free = sfrWrData[BIT_FREE];
      next_writeEnable = sfrWrData[BIT_WR_EN];
    end
    if (timerDone && eraseRow) begin
      next_free = 1'b0;
    end
    if (readStart) begin
      next_rdBit = 1'b1;
    end
    if (unlockWr) begin
      if (sfrWrData == UNLOCK_FIRST) begin
        next_unlock = UNLOCK_HALF;
      end else if (sfrWrData == UNLOCK_SECOND && unlock == UNLOCK_HALF) begin
        next_unlock = UNLOCK_OPEN;
      end else begin
        next_unlock = UNLOCK_IDLE;
      end
    end else if (sfrWrite) begin
      next_unlock = UNLOCK_IDLE;
    end
  end

  // Space selects, busy and the error flag.
  always_comb begin
    next_busy = busy;
    next_memSel = memSel;
    next_cfgSel = cfgSel;
    next_writeError = writeError;
    if (!rst_n) begin
      next_writeError = writeError | busy;
      next_busy = 1'b0;
    end else begin
      if (ctrlWr && !busy) begin
        next_memSel = sfrWrData[BIT_MEM_SEL];
        next_cfgSel = sfrWrData[BIT_CFG_SEL];
        next_writeError = sfrWrData[BIT_WR_ERR];
      end
      if (startReq) begin
        next_busy = 1'b1;
      end else if (timerDone) begin
        next_busy = 1'b0;
      end
    end
  end

  // Array commands and core status.
  always_comb begin
    next_flashAddr = flashAddr;
    next_longWriteStart = startReq;
    next_eraseRow = eraseRow;
    next_targetSpace = targetSpace;
    next_eepromReadStart = readStart;
    if ((tableReadReq || tableWriteReq) && tableOk) begin
      next_flashAddr = effPtr;
    end
    if (startReq) begin
      next_eraseRow = sfrWrData[BIT_FREE];
      if (sfrWrData[BIT_CFG_SEL]) begin
        next_targetSpace = SPACE_CONFIG;
      end else if (sfrWrData[BIT_MEM_SEL]) begin
        next_targetSpace = SPACE_PROGRAM;
      end else begin
        next_targetSpace = SPACE_EEPROM;
      end
      if (sfrWrData[BIT_FREE]) begin
        next_flashAddr = {ptr[PTR_WIDTH-1:ROW_LSBS], 6'h00};
      end else begin
        next_flashAddr = {ptr[PTR_WIDTH-1:BLOCK_LSBS], 3'h0};
      end
    end
    next_fetchStall = startReq || (busy && !timerDone);
    next_writeCompleteFlag = (writeCompleteFlag && !writeCompleteClear) || timerDone;
  end

  // Read-back of the register port, one cycle after the select.
  always_comb begin
    next_sfrRdData = 8'h00;
    if (sfrSel == SEL_CONTROL) begin
      next_sfrRdData = {memSel, cfgSel, 1'b0, free, writeError, writeEnable, busy, rdBit};
    end else if (sfrSel == SEL_LATCH) begin
      next_sfrRdData = latch;
    end else if (sfrSel == SEL_PTR_LOW) begin
      next_sfrRdData = ptr[7:0];
    end else if (sfrSel == SEL_PTR_HIGH) begin
      next_sfrRdData = ptr[15:8];
    end else if (sfrSel == SEL_PTR_UPPER) begin
      next_sfrRdData = {2'h0, ptr[21:16]};
    end
  end

  // Power-on domain: warm resets are seen synchronously here.
  always_ff @(posedge clock or negedge porRst_n) begin
    if (!porRst_n) begin
      busy <= 1'b0;
      memSel <= 1'b0;
      cfgSel <= 1'b0;
      writeError <= 1'b0;
    end else begin
      busy <= next_busy;
      memSel <= next_memSel;
      cfgSel <= next_cfgSel;
      writeError <= next_writeError;
    end
  end

  // Main registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr <= PTR_RESET;
      latch <= BYTE_RESET;
      free <= 1'b0;
      writeEnable <= 1'b0;
      rdBit <= 1'b0;
      readPending <= 1'b0;
      unlock <= UNLOCK_IDLE;
      flashAddr <= PTR_RESET;
      longWriteStart <= 1'b0;
      eraseRow <= 1'b0;
      targetSpace <= SPACE_EEPROM;
      eepromReadStart <= 1'b0;
      fetchStall <= 1'b0;
      writeCompleteFlag <= 1'b0;
      sfrRdData <= BYTE_RESET;
    end else begin
      ptr <= next_ptr;
      latch <= next_latch;
      free <= next_free;
      writeEnable <= next_writeEnable;
      rdBit <= next_rdBit;
      readPending <= next_readPending;
      unlock <= next_unlock;
      flashAddr <= next_flashAddr;
      longWriteStart <= next_longWriteStart;
      eraseRow <= next_eraseRow;
      targetSpace <= next_targetSpace;
      eepromReadStart <= next_eepromReadStart;
      fetchStall <= next_fetchStall;
      writeCompleteFlag <= next_writeCompleteFlag;
      sfrRdData <= next_sfrRdData;
    end
  end

  holding_register_bank u_holding (
    .clock(clock),
    .rst_n(rst_n),
    .loadEn(tableWriteReq && tableOk),
    .lock(busy),
    .index(effPtr[2:0]),
    .loadData(latch),
    .blockData(holdingData)
  );

  program_timer #(
    .CYCLES(PROG_TIME_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(startReq),
    .done(timerDone)
  );

  // Busy-length counter used only by the checks below.
  logic [TIMER_WIDTH:0] busyCount;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busyCount <= '0;
    end else if (busy) begin
      busyCount <= busyCount + 1'b1;
    end else begin
      busyCount <= '0;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_no_start_without_enable;
    ctrlWr && sfrWrData[BIT_WR] && !writeEnable && !busy |=> !busy && !longWriteStart;
  endproperty
  a_no_start_without_enable: assert property (p_no_start_without_enable)
    else $error("Write started with write-enable clear.");

  property p_start_stalls;
    startReq |=> fetchStall && busy && longWriteStart ##1 fetchStall && !longWriteStart;
  endproperty
  a_start_stalls: assert property (p_start_stalls)
    else $error("Fetch not stalled after write start.");

  property p_timed_length;
    $fell(busy) |-> busyCount == (TIMER_WIDTH+1)'(PROG_TIME_CYCLES);
  endproperty
  a_timed_length: assert property (p_timed_length)
    else $error("Programming time differs from the timer setting.");

  property p_read_one_cycle;
    readStart |=> rdBit && eepromReadStart ##1 !rdBit;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("Read-start did not clear after one cycle.");

  property p_read_refused;
    ctrlWr && sfrWrData[BIT_RD] && memSel |=> !rdBit && !eepromReadStart;
  endproperty
  a_read_refused: assert property (p_read_refused)
    else $error("Read-start set while program flash selected.");

  property p_unlock_reads_zero;
    sfrSel == SEL_UNLOCK |=> sfrRdData == 8'h00;
  endproperty
  a_unlock_reads_zero: assert property (p_unlock_reads_zero)
    else $error("Unlock port read back non-zero.");

  property p_top_bit_kept;
    (tableReadReq || tableWriteReq) && !busy && !sfrWrite |=> ptr[21] == $past(ptr[21]);
  endproperty
  a_top_bit_kept: assert property (p_top_bit_kept)
    else $error("Pointer update changed the space bit.");

  property p_holding_stable;
    busy && $past(busy) |-> $stable(holdingData);
  endproperty
  a_holding_stable: assert property (p_holding_stable)
    else $error("Holding registers changed during a long write.");

  property p_erase_clears_free;
    timerDone && eraseRow |=> !free && !busy && writeCompleteFlag;
  endproperty
  a_erase_clears_free: assert property (p_erase_clears_free)
    else $error("Erase-select or complete flag wrong after erase.");

  property p_complete_flag;
    timerDone |=> writeCompleteFlag ##1 (writeCompleteFlag || $past(writeCompleteClear));
  endproperty
  a_complete_flag: assert property (p_complete_flag)
    else $error("Complete flag not set or lost after write.");
endmodule : program_flash_self_programming

// >>> program_timer.sv
`timescale 1ns/1ps
module program_timer
  import flash_self_prog_pkg::*;
#(
  parameter int CYCLES = PROG_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Control.
  input wire logic start,
  output logic done
);
  logic [TIMER_WIDTH-1:0] count;
  logic [TIMER_WIDTH-1:0] next_count;
  logic next_done;
  // Counts down from the load value; done pulses as the count expires.
  always_comb begin
    next_count = count;
    next_done = 1'b0;
    if (start) begin
      next_count = TIMER_WIDTH'(CYCLES - 1);
    end else if (count != '0) begin
      next_count = count - 1'b1;
      next_done = (count == TIMER_WIDTH'(1));
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      done <= 1'b0;
    end else begin
      count <= next_count;
      done <= next_done;
    end
  end
endmodule : program_timer

// >>> test_program_flash_self_programming.sv
`timescale 1ns/1ps
module test_program_flash_self_programming
  import flash_self_prog_pkg::*;
;
  localparam int PROG_T = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic porRst_n = 1'b0;
  logic [2:0] sfrSel = 3'h0;
  logic sfrWrite = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic tableReadReq = 1'b0;
  logic tableWriteReq = 1'b0;
  ptr_action_t tableMode = PTR_KEEP;
  logic writeCompleteClear = 1'b0;
  logic [7:0] sfrRdData, flashRdData;
  logic [PTR_WIDTH-1:0] flashAddr;
  logic [8*BLOCK_BYTES-1:0] holdingData;
  logic [63:0] expBlock = 64'h0;
  logic longWriteStart, eraseRow, eepromReadStart, fetchStall, writeCompleteFlag;
  space_t targetSpace;
  int n_mismatch = 0, checked = 0, nStarts = 0, nReads = 0, nStall = 0;

  program_flash_self_programming #(.PROG_TIME_CYCLES(PROG_T)) u_dut (
    .clock(clock), .rst_n(rst_n), .porRst_n(porRst_n),
    .sfrSel(sfrSel), .sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .tableReadReq(tableReadReq), .tableWriteReq(tableWriteReq), .tableMode(tableMode),
    .flashAddr(flashAddr), .flashRdData(flashRdData), .holdingData(holdingData),
    .longWriteStart(longWriteStart), .eraseRow(eraseRow), .targetSpace(targetSpace),
    .eepromReadStart(eepromReadStart), .fetchStall(fetchStall),
    .writeCompleteFlag(writeCompleteFlag), .writeCompleteClear(writeCompleteClear)
  );
  flash_array_model u_array (.flashAddr(flashAddr), .flashRdData(flashRdData));

  // Clock generator.
  initial begin
    forever #50 clock = ~clock;
  end

  // Event counters for pulses and stall length.
  always @(posedge clock) begin
    if (longWriteStart === 1'b1) nStarts++;
    if (eepromReadStart === 1'b1) nReads++;
    if (fetchStall === 1'b1) nStall++;
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value got %h exp %h", $time, got, exp);
    end
  endtask : chk_val

  function automatic logic [7:0] exp_byte(input logic [21:0] a);
    return a[7:0] ^ {a[21], a[14:8]};
  endfunction : exp_byte

  // Register port write, held across one rising edge.
  task automatic sfr_wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clock);
    sfrSel = s;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge clock);
    sfrWrite = 1'b0;
  endtask : sfr_wr

  // Register port read, answer one edge after the select.
  task automatic sfr_rd(input logic [2:0] s, output logic [7:0] d);
    @(negedge clock);
    sfrSel = s;
    @(negedge clock);
    d = sfrRdData;
  endtask : sfr_rd

  task automatic set_ptr(input logic [21:0] p);
    sfr_wr(SEL_PTR_LOW, p[7:0]);
    sfr_wr(SEL_PTR_HIGH, p[15:8]);
    sfr_wr(SEL_PTR_UPPER, {2'h0, p[21:16]});
  endtask : set_ptr

  task automatic get_ptr(output logic [21:0] p);
    logic [7:0] l, h, u;
    sfr_rd(SEL_PTR_LOW, l);
    sfr_rd(SEL_PTR_HIGH, h);
    sfr_rd(SEL_PTR_UPPER, u);
    p = {u[5:0], h, l};
  endtask : get_ptr

  // One table instruction, then a cycle for the latch to load.
  task automatic table_op(input logic rd, input ptr_action_t m);
    @(negedge clock);
    tableReadReq = rd;
    tableWriteReq = !rd;
    tableMode = m;
    @(negedge clock);
    tableReadReq = 1'b0;
    tableWriteReq = 1'b0;
    @(negedge clock);
  endtask : table_op

  task automatic start_op(input logic [7:0] ctrl);
    sfr_wr(SEL_CONTROL, ctrl & 8'hFD);
    sfr_wr(SEL_UNLOCK, UNLOCK_FIRST);
    sfr_wr(SEL_UNLOCK, UNLOCK_SECOND);
    sfr_wr(SEL_CONTROL, ctrl);
  endtask : start_op

  task automatic wait_start();
    int i;
    for (i = 0; i < 4 && longWriteStart !== 1'b1; i++) @(negedge clock);
    chk_bit(longWriteStart, 1'b1);
  endtask : wait_start

  task automatic wait_idle();
    int i;
    for (i = 0; i < 100 && fetchStall !== 1'b0; i++) @(negedge clock);
    if (fetchStall !== 1'b0) begin
      n_mismatch++;
      $display("[FAIL] %0t stall never ended", $time);
      final_report();
    end
  endtask : wait_idle

  task automatic test_regs();
    logic [7:0] b;
    sfr_rd(SEL_CONTROL, b);
    chk_val(64'(b), 64'(8'h00));
    sfr_wr(SEL_UNLOCK, 8'h3C);
    sfr_rd(SEL_UNLOCK, b);
    chk_val(64'(b), 64'(8'h00));
  endtask : test_regs

  task automatic test_table_read();
    logic [21:0] p;
    logic [7:0] b;
    int m;
    for (m = 0; m < 4; m++) begin
      set_ptr(22'h2000F0);
      table_op(1'b1, ptr_action_t'(m));
      sfr_rd(SEL_LATCH, b);
      chk_val(64'(b), 64'(exp_byte(m == 3 ? 22'h2000F1 : 22'h2000F0)));
      get_ptr(p);
      chk_val(64'(p), 64'(22'h2000F0 + (m == 1 || m == 3) - (m == 2)));
    end
    set_ptr(22'h3FFFFF);
    table_op(1'b1, PTR_POST_INC);
    sfr_rd(SEL_LATCH, b);
    chk_val(64'(b), 64'(exp_byte(22'h3FFFFF)));
    get_ptr(p);
    chk_val(64'(p), 64'(22'h200000));
  endtask : test_table_read

  task automatic test_table_write();
    logic [21:0] p;
    int i;
    set_ptr(22'h000105);
    for (i = 0; i < 8; i++) begin
      sfr_wr(SEL_LATCH, 8'hA0 + 8'(i));
      table_op(1'b0, PTR_POST_INC);
      expBlock[8*((5+i)%8) +: 8] = 8'hA0 + 8'(i);
    end
    chk_val(holdingData, expBlock);
    get_ptr(p);
    chk_val(64'(p), 64'(22'h00010D));
  endtask : test_table_write

  task automatic test_block_write();
    logic [7:0] b;
    int s0, n0;
    s0 = nStall;
    n0 = nStarts;
    start_op(8'h86);
    wait_start();
    chk_val(64'(flashAddr), 64'(22'h000108));
    chk_bit(eraseRow, 1'b0);
    chk_val(64'(targetSpace), 64'(SPACE_PROGRAM));
    chk_bit(fetchStall, 1'b1);
    chk_val(holdingData, expBlock);
    sfr_wr(SEL_LATCH, 8'h5A);
    table_op(1'b0, PTR_KEEP);
    sfr_wr(SEL_CONTROL, 8'h80);
    chk_val(holdingData, expBlock);
    chk_bit(fetchStall, 1'b1);
    wait_idle();
    chk_val(64'(nStall - s0), 64'(PROG_T));
    chk_val(64'(nStarts - n0), 64'(1));
    chk_bit(writeCompleteFlag, 1'b1);
    sfr_rd(SEL_CONTROL, b);
    chk_bit(b[BIT_WR], 1'b0);
    @(negedge clock);
    writeCompleteClear = 1'b1;
    @(negedge clock);
    writeCompleteClear = 1'b0;
    chk_bit(writeCompleteFlag, 1'b0);
    sfr_wr(SEL_CONTROL, 8'h80);
  endtask : test_block_write

  task automatic test_erase();
    logic [7:0] b;
    set_ptr(22'h0012FF);
    start_op(8'h96);
    wait_start();
    chk_val(64'(flashAddr), 64'(22'h0012C0));
    chk_bit(eraseRow, 1'b1);
    wait_idle();
    sfr_rd(SEL_CONTROL, b);
    chk_bit(b[BIT_FREE], 1'b0);
    sfr_wr(SEL_CONTROL, 8'h80);
  endtask : test_erase

  task automatic test_refusals();
    logic [7:0] b;
    int n0, r0;
    n0 = nStarts;
    r0 = nReads;
    sfr_wr(SEL_UNLOCK, UNLOCK_FIRST);
    sfr_wr(SEL_UNLOCK, UNLOCK_SECOND);
    sfr_wr(SEL_CONTROL, 8'h82);
    sfr_rd(SEL_CONTROL, b);
    chk_bit(b[BIT_WR], 1'b0);
    sfr_wr(SEL_CONTROL, 8'h84);
    sfr_wr(SEL_CONTROL, 8'h86);
    sfr_rd(SEL_CONTROL, b);
    chk_val(64'(nStarts - n0), 64'(0));
    sfr_wr(SEL_CONTROL, 8'h81);
    sfr_rd(SEL_CONTROL, b);
    chk_val(64'(nReads - r0), 64'(0));
    // back to data memory before the read.
    sfr_wr(SEL_CONTROL, 8'h00);
    sfr_wr(SEL_CONTROL, 8'h01);
    sfr_rd(SEL_CONTROL, b);
    chk_val(64'(nReads - r0), 64'(1));
    chk_bit(b[BIT_RD], 1'b0);
  endtask : test_refusals

  task automatic test_spaces();
    logic [7:0] c [3] = '{8'h06, 8'hC6, 8'h46};
    space_t e [3] = '{SPACE_EEPROM, SPACE_CONFIG, SPACE_CONFIG};
    int i;
    for (i = 0; i < 3; i++) begin
      start_op(c[i]);
      wait_start();
      chk_val(64'(targetSpace), 64'(e[i]));
      wait_idle();
    end
    sfr_wr(SEL_CONTROL, 8'h00);
  endtask : test_spaces

  task automatic test_reset_abort();
    logic [7:0] b;
    logic [21:0] p;
    start_op(8'hC6);
    wait_start();
    @(negedge clock);
    rst_n = 1'b0;
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    chk_bit(fetchStall, 1'b0);
    sfr_rd(SEL_CONTROL, b);
    chk_val(64'(b & 8'hCA), 64'(8'hC8));
    get_ptr(p);
    chk_val(64'(p), 64'(PTR_RESET));
  endtask : test_reset_abort

  // Main sequence after the reset period.
  initial begin
    repeat (16) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    porRst_n = 1'b1;
    test_regs();
    test_table_read();
    test_table_write();
    test_block_write();
    test_erase();
    test_refusals();
    test_spaces();
    test_reset_abort();
    final_report();
  end

  // Cuts a hung run short.
  initial begin
    #(100 * 50000);
    n_mismatch++;
    $display("[FAIL] %0t run timed out", $time);
    final_report();
  end
endmodule : test_program_flash_self_programming
